// ---- logic/plc_defs.svh ----
// plc_defs.svh: offsets, field positions and reset values of the loop
// control register bank; assumes inclusion by bare name from logic/.
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

// register offsets
`define PLC_OFF_ZERO_RES 10'h01d
`define PLC_OFF_PUMP_CUR 10'h0f0
`define PLC_OFF_FB_DIV 10'h0f1
`define PLC_OFF_LOOP_CTL 10'h0f2
`define PLC_OFF_OSC_CTL 10'h0f3

// field positions
`define PLC_ZR_MSB 3
`define PLC_FB_A_MSB 7
`define PLC_FB_A_LSB 6
`define PLC_FB_B_MSB 5
`define PLC_LC_LD_PD 7
`define PLC_LC_RSVD 6
`define PLC_LC_DBL 5
`define PLC_LC_AB_SW 4
`define PLC_LC_AB_MSB 3
`define PLC_LC_AB_LSB 2
`define PLC_LC_CP_MSB 1
`define PLC_OC_FORCE_REL 4
`define PLC_OC_RSVD 3
`define PLC_OC_MID 2
`define PLC_OC_CAL 1

// reset values and fixed codes
`define PLC_RST_ZERO_RES 8'h00
`define PLC_RST_PUMP_CUR 8'h00
`define PLC_RST_FB_DIV 8'h00
`define PLC_RST_LOOP_CTL 8'h0b
`define PLC_RST_OSC_CTL 8'h00
`define PLC_AB_HIGH 2'h2
`define PLC_AB_MIN 2'h0
`define PLC_CP_NORMAL 2'h3

// writable bit masks
`define PLC_MASK_ZERO_RES 8'h0f
`define PLC_MASK_LOOP_CTL 8'hbf
`define PLC_MASK_OSC_CTL 8'h16

`endif

// ---- logic/plc_pkg.sv ----
// plc_pkg.sv: types shared by the loop control register bank;
// assumes plc_defs.svh supplies the numbers.
package plc_pkg;
    typedef logic [7:0] plc_byte_t;
    typedef logic [9:0] plc_addr_t;
    typedef enum logic [1:0] {
        PLC_CP_TRISTATE = 2'h0,
        PLC_CP_UP = 2'h1,
        PLC_CP_DOWN = 2'h2,
        PLC_CP_RUN = 2'h3
    } plc_cp_mode_t;
endpackage : plc_pkg

// ---- logic/plc_regs.sv ----
// plc_regs.sv: register bank steering the dual loop clock generator.
// assumes a simple same-clock write/read port from the serial control
// logic and an asynchronous lock level from the output loop.
// How it works
// - zero resistor code in bits [3:0]
// - eight-bit pump current magnitude held
// - divider holds A [7:6], B [5:0]
// - bit 7 powers down lock detector
// - bit 5 enables reference frequency doubler
// - switch bit zero forces high antibacklash
// - antibacklash field reads high until switched
// - switching on loads minimum antibacklash
// - charge pump mode, reset normal
// - hold sync until lock, then release
// - force bit releases sync one clock after it is set, without lock
// - bit 2 forces midscale control voltage
// - calibrate bit never self clears
`timescale 1ns/1ps
`include "plc_defs.svh"

module plc_regs (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // register port
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire plc_pkg::plc_addr_t addr_i,
    input wire plc_pkg::plc_byte_t wdata_i,
    output plc_pkg::plc_byte_t rdata_o,
    // output loop status
    input wire logic loop_locked_i,
    // analog controls
    output logic [3:0] zero_resistor_code_o,
    output logic [7:0] pump_current_o,
    output logic [1:0] fb_a_count_o,
    output logic [5:0] fb_b_count_o,
    output logic [7:0] fb_ratio_o,
    output logic lock_det_pd_o,
    output logic ref_doubler_en_o,
    output logic [1:0] antibacklash_o,
    output plc_pkg::plc_cp_mode_t cp_mode_o,
    output logic osc_midscale_o,
    output logic osc_cal_o,
    output logic dist_sync_release_o
);
    import plc_pkg::*;

    plc_byte_t zr_r, zr_nxt;
    plc_byte_t pc_r, pc_nxt;
    plc_byte_t fb_r, fb_nxt;
    plc_byte_t lc_r, lc_nxt;
    plc_byte_t oc_r, oc_nxt;
    plc_byte_t rd_r, rd_nxt;
    logic lock_s1_r, lock_s2_r;
    logic rel_r, rel_nxt;
    logic [1:0] ab_eff;
    logic [7:0] ratio;

    always_comb begin
        zr_nxt = zr_r;
        pc_nxt = pc_r;
        fb_nxt = fb_r;
        lc_nxt = lc_r;
        oc_nxt = oc_r;
        if (wr_en_i) begin
            if (addr_i == `PLC_OFF_ZERO_RES) begin
                zr_nxt = wdata_i & `PLC_MASK_ZERO_RES;
            end else if (addr_i == `PLC_OFF_PUMP_CUR) begin
                pc_nxt = wdata_i;
            end else if (addr_i == `PLC_OFF_FB_DIV) begin
                fb_nxt = wdata_i;
            end else if (addr_i == `PLC_OFF_LOOP_CTL) begin
                lc_nxt = wdata_i & `PLC_MASK_LOOP_CTL;
                if (!lc_r[`PLC_LC_AB_SW] && wdata_i[`PLC_LC_AB_SW]) begin
                    lc_nxt[`PLC_LC_AB_MSB:`PLC_LC_AB_LSB] = `PLC_AB_MIN;
                end else if (!wdata_i[`PLC_LC_AB_SW]) begin
                    lc_nxt[`PLC_LC_AB_MSB:`PLC_LC_AB_LSB] = `PLC_AB_HIGH;
                end
            end else if (addr_i == `PLC_OFF_OSC_CTL) begin
                oc_nxt = wdata_i & `PLC_MASK_OSC_CTL;
            end
        end
    end

    always_comb begin
        rd_nxt = rd_r;
        if (rd_en_i) begin
            if (addr_i == `PLC_OFF_ZERO_RES) begin
                rd_nxt = zr_r;
            end else if (addr_i == `PLC_OFF_PUMP_CUR) begin
                rd_nxt = pc_r;
            end else if (addr_i == `PLC_OFF_FB_DIV) begin
                rd_nxt = fb_r;
            end else if (addr_i == `PLC_OFF_LOOP_CTL) begin
                rd_nxt = lc_r;
            end else if (addr_i == `PLC_OFF_OSC_CTL) begin
                rd_nxt = oc_r;
            end else begin
                rd_nxt = 8'h00;
            end
        end
    end

    // lock gating of the distribution sync release
    always_comb begin
        rel_nxt = lock_s2_r | oc_r[`PLC_OC_FORCE_REL];
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            zr_r <= `PLC_RST_ZERO_RES;
            pc_r <= `PLC_RST_PUMP_CUR;
            fb_r <= `PLC_RST_FB_DIV;
            lc_r <= `PLC_RST_LOOP_CTL;
            oc_r <= `PLC_RST_OSC_CTL;
            rd_r <= 8'h00;
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
            rel_r <= 1'b0;
        end else begin
            zr_r <= zr_nxt;
            pc_r <= pc_nxt;
            fb_r <= fb_nxt;
            lc_r <= lc_nxt;
            oc_r <= oc_nxt;
            rd_r <= rd_nxt;
            lock_s1_r <= loop_locked_i;
            lock_s2_r <= lock_s1_r;
            rel_r <= rel_nxt;
        end
    end

    // effective antibacklash and divide ratio
    always_comb begin
        if (lc_r[`PLC_LC_AB_SW]) begin
            ab_eff = lc_r[`PLC_LC_AB_MSB:`PLC_LC_AB_LSB];
        end else begin
            ab_eff = `PLC_AB_HIGH;
        end
        ratio = {fb_r[`PLC_FB_B_MSB:0], 2'h0}
            + {6'h00, fb_r[`PLC_FB_A_MSB:`PLC_FB_A_LSB]};
    end

    assign rdata_o = rd_r;
    assign zero_resistor_code_o = zr_r[`PLC_ZR_MSB:0];
    assign pump_current_o = pc_r;
    assign fb_a_count_o = fb_r[`PLC_FB_A_MSB:`PLC_FB_A_LSB];
    assign fb_b_count_o = fb_r[`PLC_FB_B_MSB:0];
    assign fb_ratio_o = ratio;
    assign lock_det_pd_o = lc_r[`PLC_LC_LD_PD];
    assign ref_doubler_en_o = lc_r[`PLC_LC_DBL];
    assign antibacklash_o = ab_eff;
    assign cp_mode_o = plc_cp_mode_t'(lc_r[`PLC_LC_CP_MSB:0]);
    assign osc_midscale_o = oc_r[`PLC_OC_MID];
    assign osc_cal_o = oc_r[`PLC_OC_CAL];
    assign dist_sync_release_o = rel_r;

    // checks
    AST_ZR_UPPER_ZERO: assert property (
        @(posedge clock_i) disable iff (reset_i) zr_r[7:4] == 4'h0)
        else $error("reserved resistor bits set");
    AST_PUMP_WRITE: assert property (
        @(posedge clock_i) disable iff (reset_i)
        wr_en_i && addr_i == `PLC_OFF_PUMP_CUR
        |=> pump_current_o == $past(wdata_i))
        else $error("pump current not stored");
    AST_RATIO: assert property (
        @(posedge clock_i) disable iff (reset_i)
        fb_ratio_o == 8'(4 * fb_b_count_o + fb_a_count_o))
        else $error("divide ratio wrong");
    AST_AB_AUTO: assert property (
        @(posedge clock_i) disable iff (reset_i)
        !lc_r[`PLC_LC_AB_SW] |-> antibacklash_o == `PLC_AB_HIGH)
        else $error("antibacklash not high in auto");
    AST_AB_SWITCH_MIN: assert property (
        @(posedge clock_i) disable iff (reset_i)
        $rose(lc_r[`PLC_LC_AB_SW]) |-> antibacklash_o == 2'h0)
        else $error("antibacklash not minimum after switch");
    AST_SYNC_LOCK: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (!oc_r[`PLC_OC_FORCE_REL] && !loop_locked_i) [*4]
        |-> !dist_sync_release_o)
        else $error("sync released without lock");
    AST_SYNC_DELAY: assert property (
        @(posedge clock_i) disable iff (reset_i)
        $rose(lock_s2_r) |=> dist_sync_release_o)
        else $error("release late after lock");
    AST_FORCE_REL: assert property (
        @(posedge clock_i) disable iff (reset_i)
        oc_r[`PLC_OC_FORCE_REL] |=> dist_sync_release_o)
        else $error("forced release missing");
    AST_CAL_HOLD: assert property (
        @(posedge clock_i) disable iff (reset_i)
        osc_cal_o && !(wr_en_i && addr_i == `PLC_OFF_OSC_CTL)
        |=> osc_cal_o)
        else $error("calibrate bit cleared itself");
    AST_RD_UNMAPPED: assert property (
        @(posedge clock_i) disable iff (reset_i)
        rd_en_i && addr_i != `PLC_OFF_ZERO_RES
        && addr_i != `PLC_OFF_PUMP_CUR && addr_i != `PLC_OFF_FB_DIV
        && addr_i != `PLC_OFF_LOOP_CTL && addr_i != `PLC_OFF_OSC_CTL
        |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_RSVD_ZERO: assert property (
        @(posedge clock_i) disable iff (reset_i)
        {oc_r[7:5], oc_r[`PLC_OC_RSVD], oc_r[0], lc_r[`PLC_LC_RSVD]} == 6'h00)
        else $error("reserved control bits set");
    AST_ZR_WRITE: assert property (
        @(posedge clock_i) disable iff (reset_i)
        wr_en_i && addr_i == `PLC_OFF_ZERO_RES
        |=> zero_resistor_code_o == $past(wdata_i[`PLC_ZR_MSB:0]))
        else $error("resistor code not stored");
    AST_LD_PD: assert property (
        @(posedge clock_i) disable iff (reset_i)
        wr_en_i && addr_i == `PLC_OFF_LOOP_CTL
        |=> lock_det_pd_o == $past(wdata_i[`PLC_LC_LD_PD]))
        else $error("lock detector power-down not stored");
    AST_DOUBLER: assert property (
        @(posedge clock_i) disable iff (reset_i)
        wr_en_i && addr_i == `PLC_OFF_LOOP_CTL
        |=> ref_doubler_en_o == $past(wdata_i[`PLC_LC_DBL]))
        else $error("doubler enable not stored");
    AST_AB_KEEP: assert property (
        @(posedge clock_i) disable iff (reset_i)
        wr_en_i && addr_i == `PLC_OFF_LOOP_CTL && lc_r[`PLC_LC_AB_SW]
        && wdata_i[`PLC_LC_AB_SW]
        |=> antibacklash_o == $past(wdata_i[`PLC_LC_AB_MSB:`PLC_LC_AB_LSB]))
        else $error("programmed antibacklash not applied");
    AST_CP_MODE: assert property (
        @(posedge clock_i) disable iff (reset_i)
        wr_en_i && addr_i == `PLC_OFF_LOOP_CTL
        |=> cp_mode_o == $past(wdata_i[`PLC_LC_CP_MSB:0]))
        else $error("charge pump mode not stored");
    AST_MIDSCALE: assert property (
        @(posedge clock_i) disable iff (reset_i)
        wr_en_i && addr_i == `PLC_OFF_OSC_CTL
        |=> osc_midscale_o == $past(wdata_i[`PLC_OC_MID]))
        else $error("midscale force not stored");
    COV_AB_SWITCH: cover property (@(posedge clock_i)
        $rose(lc_r[`PLC_LC_AB_SW]));
    COV_LOCK_REL: cover property (@(posedge clock_i)
        $rose(dist_sync_release_o) && !oc_r[`PLC_OC_FORCE_REL]);
    COV_FORCE_REL: cover property (@(posedge clock_i)
        oc_r[`PLC_OC_FORCE_REL] && !loop_locked_i);
    COV_CAL: cover property (@(posedge clock_i) $rose(osc_cal_o));
endmodule : plc_regs

// ---- verif/plc_regs_tb.sv ----
// plc_regs_tb.sv: self-checking bench for the loop control register bank.
// assumes plc_pkg and plc_defs.svh from logic/; bench drives every port.
`timescale 1ns/1ps
`include "plc_defs.svh"

module plc_regs_tb;
    import plc_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    plc_addr_t addr_i = 10'h000;
    plc_byte_t wdata_i = 8'h00;
    logic loop_locked_i = 1'b0;
    plc_byte_t rdata_o;
    logic [3:0] zr_o;
    logic [7:0] pump_o, ratio_o;
    logic [1:0] a_o, ab_o;
    logic [5:0] b_o;
    logic ld_pd_o, dbl_o, mid_o, cal_o, rel_o;
    plc_cp_mode_t cp_o;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    plc_regs dut_u (.clock_i(clock_i), .reset_i(reset_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .loop_locked_i(loop_locked_i),
        .zero_resistor_code_o(zr_o), .pump_current_o(pump_o),
        .fb_a_count_o(a_o), .fb_b_count_o(b_o), .fb_ratio_o(ratio_o),
        .lock_det_pd_o(ld_pd_o), .ref_doubler_en_o(dbl_o),
        .antibacklash_o(ab_o), .cp_mode_o(cp_o), .osc_midscale_o(mid_o),
        .osc_cal_o(cal_o), .dist_sync_release_o(rel_o));

    always #2 clock_i = ~clock_i;

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic chk(input plc_byte_t got, input plc_byte_t exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input plc_addr_t a, input plc_byte_t d);
        @(negedge clock_i);
        wr_en_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(negedge clock_i);
        wr_en_i = 1'b0;
    endtask : wr

    task automatic rd(input plc_addr_t a, input plc_byte_t e);
        @(negedge clock_i);
        rd_en_i = 1'b1;
        addr_i = a;
        @(negedge clock_i);
        rd_en_i = 1'b0;
        chk(rdata_o, e);
    endtask : rd

    task automatic t_reset();
        rd(`PLC_OFF_ZERO_RES, 8'h00);
        rd(`PLC_OFF_LOOP_CTL, 8'h0b);
        rd(`PLC_OFF_OSC_CTL, 8'h00);
        chk({6'h00, ab_o}, 8'h02);
        chk({7'h00, rel_o}, 8'h00);
    endtask : t_reset

    task automatic t_fields();
        wr(`PLC_OFF_ZERO_RES, 8'hff);
        chk({4'h0, zr_o}, 8'h0f);
        rd(`PLC_OFF_ZERO_RES, 8'h0f);
        wr(`PLC_OFF_PUMP_CUR, 8'ha5);
        chk(pump_o, 8'ha5);
        wr(`PLC_OFF_FB_DIV, 8'hc7);
        chk({a_o, b_o}, 8'hc7);
        chk(ratio_o, 8'h1f);
        wr(`PLC_OFF_FB_DIV, 8'hff);
        chk(ratio_o, 8'hff);
        wr(10'h0f4, 8'h5a);
        chk(pump_o, 8'ha5);
        rd(10'h0f4, 8'h00);
    endtask : t_fields

    task automatic t_loop();
        wr(`PLC_OFF_LOOP_CTL, 8'ha3);
        chk({6'h00, ld_pd_o, dbl_o}, 8'h03);
        chk({6'h00, ab_o}, 8'h02);
        rd(`PLC_OFF_LOOP_CTL, 8'hab);
        wr(`PLC_OFF_LOOP_CTL, 8'h1f);
        chk({6'h00, ab_o}, 8'h00);
        wr(`PLC_OFF_LOOP_CTL, 8'h1c);
        chk({6'h00, ab_o}, 8'h03);
        for (int m = 0; m < 4; m++) begin
            wr(`PLC_OFF_LOOP_CTL, 8'h14 | 8'(m));
            chk({6'h00, cp_o}, 8'(m));
            chk({6'h00, ab_o}, 8'h01);
        end
        wr(`PLC_OFF_LOOP_CTL, 8'h0f);
        chk({6'h00, ab_o}, 8'h02);
    endtask : t_loop

    task automatic t_osc();
        wr(`PLC_OFF_OSC_CTL, 8'hf7);
        @(negedge clock_i);
        chk({7'h00, rel_o}, 8'h01);
        rd(`PLC_OFF_OSC_CTL, 8'h16);
        repeat (5) @(negedge clock_i);
        chk({6'h00, mid_o, cal_o}, 8'h03);
        wr(`PLC_OFF_OSC_CTL, 8'h00);
        chk({6'h00, mid_o, cal_o}, 8'h00);
        repeat (2) @(negedge clock_i);
        chk({7'h00, rel_o}, 8'h00);
    endtask : t_osc

    task automatic t_lock();
        loop_locked_i = 1'b1;
        repeat (2) @(negedge clock_i);
        chk({7'h00, rel_o}, 8'h00);
        repeat (2) @(negedge clock_i);
        chk({7'h00, rel_o}, 8'h01);
        loop_locked_i = 1'b0;
        repeat (4) @(negedge clock_i);
        chk({7'h00, rel_o}, 8'h00);
    endtask : t_lock

    initial begin
        repeat (20) @(negedge clock_i);
        reset_i = 1'b0;
        t_reset();
        t_fields();
        t_loop();
        t_osc();
        t_lock();
        conclude();
    end
endmodule : plc_regs_tb
